// ==== i2m_pkg.sv ====
// Package of constants and types for the two-wire register access host.
// Assumes a 250 MHz system clock and a slave that answers with a fixed 1001 address prefix.
package i2m_pkg;
   // System clock period and the quarter of one bus bit period (400 kHz bus).
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_QUARTER_NS  = 625;
   // A quarter bit is a least time, so the cycle count rounds up.
   localparam logic [7:0] QUARTER_CYC =
      8'((T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Fixed upper four bits of the slave address.
   localparam logic [3:0] ADDR_PREFIX = 4'h9;
   // Bit index of the acknowledge slot within a nine-bit byte frame.
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // Bit index of the last data bit of a byte.
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   // Reset values of the bus levels: both lines released high.
   localparam logic LINE_IDLE = 1'b1;
   // Operations that the bit engine carries out, each four quarter bits long.
   typedef enum logic [1:0] {
      OP_START,
      OP_STOP,
      OP_BIT
   } i2m_op_type;
   // Transfer kinds that the user may request.
   typedef enum logic [1:0] {
      KIND_WRITE    = 2'h0,
      KIND_SET_ADDR = 2'h1,
      KIND_RECEIVE  = 2'h2,
      KIND_COMBINED = 2'h3
   } i2m_kind_type;
endpackage

// ==== i2m_bit_if.sv ====
// Interface between the byte sequencer and the bit engine of the host.
// Assumes both ends run on the same clock; req is a level held until done.
`timescale 1ns/10ps
interface i2m_bit_if;
   logic               req;     // Operation pending.
   i2m_pkg::i2m_op_type op;     // Operation to run.
   logic               tx_bit;  // Level to put on the data line for a bit.
   logic               done;    // One-cycle pulse at the end of an operation.
   logic               rx_bit;  // Data line level sampled in the clock high phase.
   modport ctl (output req, output op, output tx_bit, input done, input rx_bit);
   modport eng (input req, input op, input tx_bit, output done, output rx_bit);
endinterface

// ==== i2m_bit_engine.sv ====
// Bit engine of the two-wire host: makes start, stop and single bit frames on the pins.
// Assumes open-drain pins resolved outside; scl_i and sda_i come from the pins, unsynchronised.
`timescale 1ns/10ps
module i2m_bit_engine (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic ce,
   i2m_bit_if.eng    bus,
   input  wire logic scl_i,
   output logic      scl_o,
   output logic      scl_oe,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe
);
   logic                scl_s1_r, scl_s2_r;   // Clock pin synchroniser.
   logic                sda_s1_r, sda_s2_r;   // Data pin synchroniser.
   logic                busy_r;               // An operation is running.
   logic [1:0]          phase_r;              // Quarter bit within the operation.
   logic [7:0]          cnt_r;                // Cycles within the quarter bit.
   i2m_pkg::i2m_op_type op_r;                 // Operation being run.
   logic                tx_r;                 // Data level for a bit operation.
   logic                scl_lvl_r, sda_lvl_r; // Levels the host wants on the lines.
   logic                rx_r;                 // Sampled data bit.
   logic                step;                 // The current quarter bit has ended.

   // Line levels {scl, sda} for each quarter of each operation.
   function automatic logic [1:0] lv(i2m_pkg::i2m_op_type op, logic [1:0] ph, logic tx);
      logic [1:0] r;
      r = {1'b0, tx};
      case (op)
         i2m_pkg::OP_START: r = (ph == 2'h0) ? 2'h1 : (ph == 2'h1) ? 2'h3 :
                                (ph == 2'h2) ? 2'h2 : 2'h0;
         i2m_pkg::OP_STOP:  r = (ph == 2'h0) ? 2'h0 : (ph == 2'h1) ? 2'h2 : 2'h3;
         default:           r = {(ph == 2'h1) || (ph == 2'h2), tx};
      endcase
      return r;
   endfunction

   // Two flip-flops on each pin before anything reads it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r} <= 4'hF;
      end else if (ce) begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
      end
   end

   // A quarter ends only once the clock line really shows our level, so a
   // slave that holds the clock low simply stretches the bit.
   assign step = busy_r && (scl_s2_r == scl_lvl_r) && (cnt_r == i2m_pkg::QUARTER_CYC - 8'h01);
   assign bus.done   = ce && step && (phase_r == 2'h3);
   assign bus.rx_bit = rx_r;

   // Operation sequencing through four quarter bits.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_r    <= 1'b0;
         phase_r   <= 2'h0;
         cnt_r     <= 8'h00;
         op_r      <= i2m_pkg::OP_BIT;
         tx_r      <= 1'b1;
         scl_lvl_r <= i2m_pkg::LINE_IDLE;
         sda_lvl_r <= i2m_pkg::LINE_IDLE;
      end else if (ce) begin
         if (!busy_r) begin
            // Take a new operation; its first quarter starts at once.
            if (bus.req) begin
               busy_r                 <= 1'b1;
               op_r                   <= bus.op;
               tx_r                   <= bus.tx_bit;
               phase_r                <= 2'h0;
               cnt_r                  <= 8'h00;
               {scl_lvl_r, sda_lvl_r} <= lv(bus.op, 2'h0, bus.tx_bit);
            end
         end else if (step) begin
            cnt_r <= 8'h00;
            if (phase_r == 2'h3) begin
               busy_r <= 1'b0;
            end else begin
               phase_r                <= phase_r + 2'h1;
               {scl_lvl_r, sda_lvl_r} <= lv(op_r, phase_r + 2'h1, tx_r);
            end
         end else if (scl_s2_r == scl_lvl_r) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   // The data line is sampled at the end of the second clock high quarter.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_r <= 1'b1;
      end else if (ce && step && phase_r == 2'h2) begin
         rx_r <= sda_s2_r;
      end
   end

   // Open drain: the enable is high only while a line is pulled low.
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = !scl_lvl_r;
   assign sda_oe = !sda_lvl_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_sda_steady: assert property (op_r == i2m_pkg::OP_BIT && $past(scl_lvl_r) && scl_lvl_r
      |-> $stable(sda_lvl_r)) else $error("data moved while clock high");
   a_start_form: assert property ($fell(sda_lvl_r) && $past(scl_lvl_r)
      |-> op_r == i2m_pkg::OP_START && scl_lvl_r) else $error("stray start");
   a_stop_form: assert property ($rose(sda_lvl_r) && $past(scl_lvl_r)
      |-> op_r == i2m_pkg::OP_STOP && scl_lvl_r) else $error("stray stop");
endmodule

// ==== i2m_host.sv ====
// Host controller that reads and writes the byte register space of a two-wire slave.
// Assumes open-drain pins resolved outside and a user that streams write bytes on request.
//
// Summary of operation
// - Data changes only while the clock is low; start and stop change it with the clock high.
// - Every transfer opens with a start condition.
// - Every transfer closes with a stop condition.
// - Bytes are eight bits, MSB first, then acknowledge.
// - Receiver acknowledges by pulling data low.
// - Released data in the ninth pulse means no-acknowledge.
// - First byte: seven address bits plus direction bit.
// - Write sends register address, high byte first.
// - Address-only write sets the read start address.
// - Combined read: address write, repeated start, read.
// - Master pulls data low, then releases for stop.
`timescale 1ns/10ps
module i2m_host (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  ce,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire i2m_pkg::i2m_kind_type cmd_kind,
   input  wire logic [15:0]           cmd_reg_addr,
   input  wire logic [15:0]           cmd_rd_count,
   input  wire logic                  wr_valid,
   output logic                       wr_ready,
   input  wire logic [7:0]            wr_data,
   input  wire logic                  wr_last,
   output logic                       rd_valid,
   output logic [7:0]                 rd_data,
   output logic                       rd_last,
   output logic                       busy,
   output logic                       xfer_done,
   output logic                       xfer_nack,
   input  wire logic                  strap_pin_addr_bit0,
   input  wire logic                  strap_pin_addr_bit1,
   input  wire logic                  strap_pin_addr_bit2,
   input  wire logic                  scl_i,
   output logic                       scl_o,
   output logic                       scl_oe,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe
);
   // Byte sequencer states.
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_START,
      ST_ADDR,
      ST_REGHI,
      ST_REGLO,
      ST_WLOAD,
      ST_WDATA,
      ST_RSTART,
      ST_RADDR,
      ST_RDATA,
      ST_STOP
   } i2m_state_type;

   i2m_bit_if             bus ();         // Link to the bit engine.
   i2m_state_type         state_r;        // Sequencer state.
   i2m_pkg::i2m_kind_type kind_r;         // Kind of the running transfer.
   logic [15:0]           reg_addr_r;     // Register address to send.
   logic [15:0]           rd_left_r;      // Read bytes still to come after this one.
   logic [7:0]            shift_r;        // Byte being sent or received.
   logic [3:0]            bit_cnt_r;      // Bit within the byte, eight is the acknowledge.
   logic                  last_r;         // The byte being written is the last.
   logic [2:0]            strap_s1_r;     // Strap pins, first synchroniser stage.
   logic [2:0]            strap_s2_r;     // Strap pins, second synchroniser stage.
   logic                  rd_valid_r;     // Read byte strobe.
   logic [7:0]            rd_data_r;      // Read byte.
   logic                  rd_last_r;      // Read byte is the final one.
   logic                  done_r;         // Transfer finished strobe.
   logic                  nack_r;         // Last transfer was refused.
   logic                  is_rd_dir;      // Address byte carries the read direction.
   logic [7:0]            slave_byte;     // Address byte for the current phase.

   // States that send a byte and read back its acknowledge.
   function automatic logic is_send(i2m_state_type s);
      return (s == ST_ADDR) || (s == ST_REGHI) || (s == ST_REGLO) ||
             (s == ST_WDATA) || (s == ST_RADDR);
   endfunction

   // The strap pins come from outside and pass two flip-flops.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_s1_r <= 3'h0;
         strap_s2_r <= 3'h0;
      end else if (ce) begin
         strap_s1_r <= {strap_pin_addr_bit2, strap_pin_addr_bit1, strap_pin_addr_bit0};
         strap_s2_r <= strap_s1_r;
      end
   end

   // Slave address byte: fixed prefix, strap bits, then the direction bit.
   assign is_rd_dir  = (state_r == ST_RSTART) || (kind_r == i2m_pkg::KIND_RECEIVE);
   assign slave_byte = {i2m_pkg::ADDR_PREFIX, strap_s2_r, is_rd_dir};

   // Requests to the bit engine follow the state directly.
   always_comb begin
      bus.req    = (state_r != ST_IDLE) && (state_r != ST_WLOAD);
      bus.op     = i2m_pkg::OP_BIT;
      bus.tx_bit = 1'b1;
      if (state_r == ST_START || state_r == ST_RSTART) begin
         bus.op = i2m_pkg::OP_START;
      end else if (state_r == ST_STOP) begin
         bus.op = i2m_pkg::OP_STOP;
      end else if (state_r == ST_RDATA) begin
         // Acknowledge every read byte except the last, which is refused.
         bus.tx_bit = (bit_cnt_r == i2m_pkg::ACK_SLOT) ? (rd_left_r == 16'h0000) : 1'b1;
      end else if (is_send(state_r)) begin
         // Data MSB first, then release the line for the slave's answer.
         bus.tx_bit = (bit_cnt_r == i2m_pkg::ACK_SLOT) ? 1'b1 : shift_r[7];
      end
   end

   // Byte sequencing: one step per finished bit engine operation.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= ST_IDLE;
         kind_r     <= i2m_pkg::KIND_WRITE;
         reg_addr_r <= 16'h0000;
         rd_left_r  <= 16'h0000;
         shift_r    <= 8'h00;
         bit_cnt_r  <= 4'h0;
         last_r     <= 1'b0;
      end else if (ce) begin
         case (state_r)
            ST_IDLE: begin
               if (cmd_valid) begin
                  kind_r     <= cmd_kind;
                  reg_addr_r <= cmd_reg_addr;
                  rd_left_r  <= cmd_rd_count;
                  state_r    <= ST_START;
               end
            end
            ST_START, ST_RSTART: begin
               if (bus.done) begin
                  shift_r   <= slave_byte;
                  bit_cnt_r <= 4'h0;
                  state_r   <= (state_r == ST_RSTART) ? ST_RADDR : ST_ADDR;
               end
            end
            ST_WLOAD: begin
               // Write data is streamed; there is no limit on the count.
               if (wr_valid) begin
                  shift_r <= wr_data;
                  last_r  <= wr_last;
                  state_r <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (bus.done) begin
                  if (bit_cnt_r != i2m_pkg::ACK_SLOT) begin
                     shift_r   <= {shift_r[6:0], bus.rx_bit};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else begin
                     bit_cnt_r <= 4'h0;
                     rd_left_r <= rd_left_r - 16'h0001;
                     // The slave lets go after the refusal, so the stop follows.
                     if (rd_left_r == 16'h0000) begin
                        state_r <= ST_STOP;
                     end
                  end
               end
            end
            ST_STOP: begin
               if (bus.done) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               // Byte sending states.
               if (bus.done) begin
                  if (bit_cnt_r != i2m_pkg::ACK_SLOT) begin
                     shift_r   <= {shift_r[6:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else begin
                     bit_cnt_r <= 4'h0;
                     if (bus.rx_bit) begin
                        // A refused byte ends the transfer at once.
                        state_r <= ST_STOP;
                     end else begin
                        case (state_r)
                           ST_ADDR: begin
                              if (kind_r == i2m_pkg::KIND_RECEIVE) begin
                                 state_r <= ST_RDATA;
                              end else begin
                                 shift_r <= reg_addr_r[15:8];
                                 state_r <= ST_REGHI;
                              end
                           end
                           ST_REGHI: begin
                              shift_r <= reg_addr_r[7:0];
                              state_r <= ST_REGLO;
                           end
                           ST_REGLO: begin
                              if (kind_r == i2m_pkg::KIND_WRITE) begin
                                 state_r <= ST_WLOAD;
                              end else if (kind_r == i2m_pkg::KIND_COMBINED) begin
                                 state_r <= ST_RSTART;
                              end else begin
                                 state_r <= ST_STOP;
                              end
                           end
                           ST_WDATA: begin
                              state_r <= last_r ? ST_STOP : ST_WLOAD;
                           end
                           default: begin
                              state_r <= ST_RDATA;
                           end
                        endcase
                     end
                  end
               end
            end
         endcase
      end
   end

   // Read bytes are presented once their last data bit is in.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_valid_r <= 1'b0;
         rd_data_r  <= 8'h00;
         rd_last_r  <= 1'b0;
      end else if (ce) begin
         rd_valid_r <= 1'b0;
         if (state_r == ST_RDATA && bus.done && bit_cnt_r == i2m_pkg::LAST_DATA_BIT) begin
            rd_valid_r <= 1'b1;
            rd_data_r  <= {shift_r[6:0], bus.rx_bit};
            rd_last_r  <= (rd_left_r == 16'h0000);
         end
      end
   end

   // Transfer status: done pulses at the end of the stop, refusal holds until
   // the next command so that software may look at it late.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_r <= 1'b0;
         nack_r <= 1'b0;
      end else if (ce) begin
         done_r <= (state_r == ST_STOP) && bus.done;
         if (state_r == ST_IDLE && cmd_valid) begin
            nack_r <= 1'b0;
         end else if (is_send(state_r) && bus.done && bit_cnt_r == i2m_pkg::ACK_SLOT &&
                      bus.rx_bit) begin
            nack_r <= 1'b1;
         end
      end
   end

   assign cmd_ready = ce && (state_r == ST_IDLE);
   assign wr_ready  = ce && (state_r == ST_WLOAD);
   assign busy      = (state_r != ST_IDLE);
   assign rd_valid  = rd_valid_r;
   assign rd_data   = rd_data_r;
   assign rd_last   = rd_last_r;
   assign xfer_done = done_r;
   assign xfer_nack = nack_r;

   // Bit engine owns the pins.
   i2m_bit_engine u_eng (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .bus     (bus.eng),
      .scl_i   (scl_i),
      .scl_o   (scl_o),
      .scl_oe  (scl_oe),
      .sda_i   (sda_i),
      .sda_o   (sda_o),
      .sda_oe  (sda_oe)
   );

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_nack_stop: assert property (ce && bus.done && is_send(state_r) && bus.rx_bit &&
      bit_cnt_r == i2m_pkg::ACK_SLOT |=> state_r == ST_STOP) else $error("nack not stopped");
   a_addr_byte: assert property (state_r == ST_ADDR && bit_cnt_r == 4'h0
      |-> shift_r[7:4] == i2m_pkg::ADDR_PREFIX &&
          shift_r[0] == (kind_r == i2m_pkg::KIND_RECEIVE)) else $error("bad address byte");
   a_read_nack: assert property (state_r == ST_RDATA && bit_cnt_r == i2m_pkg::ACK_SLOT &&
      !scl_oe |-> sda_oe == (rd_left_r != 16'h0000)) else $error("wrong read acknowledge");
   a_reg_order: assert property ($rose(state_r == ST_REGLO)
      |-> $past(state_r) == ST_REGHI) else $error("register bytes out of order");
   a_rstart_order: assert property ($rose(state_r == ST_RADDR)
      |-> $past(state_r) == ST_RSTART) else $error("read address without repeated start");
endmodule

// ==== i2m_slave_model.sv ====
// Behavioural register access slave on the two-wire bus.
// Assumes pulled-up lines resolved outside; it pulls data only.
`timescale 1ns/10ps
module i2m_slave_model #(
   parameter logic [6:0] SLAVE_ADDR = 7'h4D
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      sda_pull
);
   logic [7:0]  mem [logic [15:0]] = '{default: 8'h3C}; // Unwritten bytes read 3C.
   logic [15:0] ptr_r = 16'h0000; // Current address, kept between transfers.
   logic [7:0]  sh_r;             // Byte shifted in or out.
   int          cnt_r;            // Bits done in the nine-bit frame.
   int          ph_r;             // Byte number in the transfer.
   logic        act_r = 1'b0;     // Selected.
   logic        rd_r;             // Read direction.
   initial sda_pull = 1'b0;
   // A start restarts the frame from any state, so a cut byte is lost.
   always @(negedge sda) if (scl === 1'b1) begin
      act_r = 1'b1;
      rd_r = 1'b0;
      // The clock fall that closes the start is not a bit, so count from one below zero.
      cnt_r = -1;
      ph_r = 0;
      sda_pull = 1'b0;
   end
   // A stop ends the transfer.
   always @(posedge sda) if (scl === 1'b1) begin
      act_r = 1'b0;
      sda_pull = 1'b0;
   end
   // Bits are taken in the high phase; a read no-acknowledge ends it.
   always @(posedge scl) if (act_r) begin
      if (cnt_r < 8 && !rd_r) sh_r = {sh_r[6:0], sda};
      else if (cnt_r == 8 && rd_r && sda) act_r = 1'b0;
   end
   // Data moves only after the clock falls.
   always @(negedge scl) if (act_r) begin
      cnt_r = cnt_r + 1;
      sda_pull = 1'b0;
      if (cnt_r == 8 && !rd_r) begin
         if (ph_r == 0) begin
            act_r = (sh_r[7:1] == SLAVE_ADDR);
            rd_r = sh_r[0];
         end else if (ph_r == 1) ptr_r[15:8] = sh_r;
         else if (ph_r == 2) ptr_r[7:0] = sh_r;
         else begin
            mem[ptr_r] = sh_r;
            ptr_r = ptr_r + 16'h0001;
         end
         ph_r = ph_r + 1;
         sda_pull = act_r;
      end else if (cnt_r == 8) ptr_r = ptr_r + 16'h0001;
      if (cnt_r == 9) cnt_r = 0;
      if (rd_r && cnt_r == 0) sh_r = mem[ptr_r];
      if (rd_r && cnt_r < 8) sda_pull = !sh_r[7 - cnt_r];
   end
endmodule

// ==== tb_i2m_host.sv ====
// Self-checking bench of the two-wire host against the slave model.
// Assumes pulled-up lines: a line is low only while someone pulls it.
`timescale 1ns/10ps
module tb_i2m_host;
   logic                  clk, reset_n, cmd_valid, cmd_ready; // Clock and command.
   i2m_pkg::i2m_kind_type cmd_kind;                          // Transfer kind.
   logic [15:0]           cmd_reg_addr, cmd_rd_count;        // Address, reads minus one.
   logic                  wr_valid, wr_ready, wr_last, rd_valid, rd_last;
   logic                  busy, xfer_done, xfer_nack, scl_oe, sda_oe, sda_pull;
   logic [7:0]            wr_data, rd_data;
   logic [2:0]            strap;                             // Slave address low bits.
   wire                   scl = !scl_oe;                     // Only the host pulls it.
   wire                   sda = !(sda_oe || sda_pull);
   int                    error_cnt = 0, check_count = 0, wi;
   logic [7:0]            wq[$], rdq[$];                     // Bytes out, bytes back.
   logic                  lastf;                             // Flag of the final read.
   logic                  ce;                                // Clock enable to the host.
   i2m_host u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_reg_addr(cmd_reg_addr),
      .cmd_rd_count(cmd_rd_count), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .wr_last(wr_last), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_last(rd_last), .busy(busy), .xfer_done(xfer_done), .xfer_nack(xfer_nack),
      .strap_pin_addr_bit0(strap[0]), .strap_pin_addr_bit1(strap[1]),
      .strap_pin_addr_bit2(strap[2]), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   i2m_slave_model #(.SLAVE_ADDR(7'h4D)) u_slave (.scl(scl), .sda(sda), .sda_pull(sda_pull));
   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One transfer; write bytes are offered on request, read bytes queued.
   task automatic run(input i2m_pkg::i2m_kind_type k, input logic [15:0] a, n);
      int t;
      t = 0;
      wi = 0;
      rdq.delete();
      cmd_kind = k;
      cmd_reg_addr = a;
      cmd_rd_count = n;
      cmd_valid = 1'b1;
      chk(cmd_ready, 1);
      @(negedge clk);
      cmd_valid = 1'b0;
      while (xfer_done !== 1'b1 && t < 40000) begin
         @(negedge clk);
         t++;
         if (wr_valid) begin
            wi++;
            wr_valid = 1'b0;
         end else if (wr_ready === 1'b1) begin
            wr_valid = 1'b1;
            wr_data = wq[wi];
            wr_last = (wi == wq.size() - 1);
         end
         if (rd_valid === 1'b1) begin
            rdq.push_back(rd_data);
            lastf = rd_last;
         end
      end
      chk(t < 40000, 1);
   endtask
   // With the enable low a pending command must wait untouched.
   task automatic t_ce_hold;
      ce = 1'b0;
      cmd_valid = 1'b1;
      repeat (3) @(negedge clk);
      chk(cmd_ready, 0);
      chk(busy, 0);
      cmd_valid = 1'b0;
      ce = 1'b1;
      @(negedge clk);
      chk(busy, 0);
   endtask
   // Two bytes at the top of the range: the second lands after the wrap.
   task automatic t_write;
      wq = '{8'hA5, 8'h5A};
      run(i2m_pkg::KIND_WRITE, 16'hFFFF, 16'h0000);
      chk(xfer_nack, 0);
      chk(u_slave.mem[16'hFFFF], 8'hA5);
      chk(u_slave.mem[16'h0000], 8'h5A);
      chk(u_slave.ptr_r, 16'h0001);
   endtask
   task automatic t_set_recv;
      run(i2m_pkg::KIND_SET_ADDR, 16'hFFFF, 16'h0000);
      chk(u_slave.mem.num(), 2);
      run(i2m_pkg::KIND_RECEIVE, 16'h0000, 16'h0001);
      chk(rdq.size(), 2);
      chk(rdq[0], 8'hA5);
      chk(rdq[1], 8'h5A);
      chk(lastf, 1);
   endtask
   task automatic t_combined;
      run(i2m_pkg::KIND_COMBINED, 16'hFFFF, 16'h0000);
      chk(rdq.size(), 1);
      chk(rdq[0], 8'hA5);
   endtask
   // A slave address that nobody owns must end in a no-acknowledge.
   task automatic t_wrong_addr;
      strap = 3'h2;
      repeat (4) @(negedge clk);
      wq = '{8'h11};
      run(i2m_pkg::KIND_WRITE, 16'h0000, 16'h0000);
      chk(xfer_nack, 1);
      chk(u_slave.mem.num(), 2);
      strap = 3'h5;
   endtask
   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      cmd_valid = 1'b0;
      wr_valid = 1'b0;
      wr_last = 1'b0;
      wr_data = 8'h00;
      cmd_kind = i2m_pkg::KIND_WRITE;
      cmd_reg_addr = 16'h0000;
      cmd_rd_count = 16'h0000;
      strap = 3'h5;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(busy, 0);
      t_ce_hold();
      t_write();
      t_set_recv();
      t_combined();
      t_wrong_addr();
      final_report();
   end
   // Cuts a hang short.
   initial begin
      repeat (125000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule
